// File: include/adc_host_pkg.sv
// Overview of operation
// - serial clock invert picks the update edge of the external clock only
// - external clock: rise updates, inverted uses fall
// - parallel mode drives bits ten/eleven, serial repurposes
// - internal clock, sync high while data valid
// - inverted sync: low while data valid
// - unfinished external read at conversion end: overrun
// - bits twelve to fifteen always driven outside reset
// - busy high from start until result latched
// - bus enabled only when select and read low
// - chip select gates the external serial clock
// - reset pin resets logic, aborts conversion
// - power down finishes conversion, then inhibits more
// - start high after acquisition: wait falling edge
// - start low after acquisition: convert immediately
// - clock select makes serial clock input or output
// - result shifted out most significant bit first
// - internal clock: read mode select allows reading during conversion
package adc_host_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned ACQ_TIME_NS     = 1500;
  localparam int unsigned CONV_TIME_NS    = 8000;
  localparam int unsigned SCLK_HALF_NS    = 100;
  // least times round up to whole cycles
  localparam int unsigned ACQ_CYCLES      = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // half period of the generated clock rounds down, never below one
  localparam int unsigned SCLK_HALF_RAW   = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned SCLK_HALF_CYCLES = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

  ////////////////////////////////////////////////////////////////////////////////
  // word and pin layout
  localparam int unsigned WORD_BITS       = 16;
  localparam int unsigned BUF_DEPTH       = 2;
  localparam int unsigned SERIAL_DATA_OUT_POS       = 8;
  localparam int unsigned SCLK_POS        = 9;
  localparam int unsigned SYNC_POS        = 10;
  localparam int unsigned OVR_POS         = 11;
  localparam int unsigned UPPER_LSB       = 12;
  localparam int unsigned SERIAL_IN_TOP   = 7;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0]
  {
    CV_ACQ  = 2'b00,
    CV_WAIT = 2'b01,
    CV_CONV = 2'b11,
    CV_PDN  = 2'b10
  } conv_state_t;

  typedef struct packed
  {
    logic serial;
    logic ext_clk;
    logic inv_sclk;
    logic inv_sync;
    logic rd_conv;
  } mode_cfg_t;

  typedef struct packed
  {
    logic cs_n;
    logic rd_n;
    logic convert_start_n_n;
    logic pd;
    logic reset;
    logic sclk;
  } host_pins_t;

  localparam int unsigned SYNC_WIDTH      = 11;
  // idle levels: select, read and start high, everything else low
  localparam logic [10:0] SYNC_RESET      = 11'h038;

endpackage

// File: hw/adc_result_buffer.sv
module adc_result_buffer #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  // pointers carry a wrap bit so full and empty are told apart
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("buffer depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  ////////////////////////////////////////////////////////////////////////////////
  // flags and pointer steps
  always_comb
  begin
    full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    empty       = (wr_q == rd_q);
    o_in_ready  = !full;
    o_out_valid = !empty;
    push        = i_in_valid && !full;
    pop         = i_out_ready && !empty;
    wr_d        = push ? wr_q + 1'b1 : wr_q;
    rd_d        = pop ? rd_q + 1'b1 : rd_q;
    o_out_data  = mem_q[rd_q[AW-1:0]];
  end

  // storage has no reset: the pointers say what is meaningful
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
    if (!i_rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

endmodule

// File: hw/adc_host_if.sv
module adc_host_if #(
  parameter int unsigned ACQ_CYC   = adc_host_pkg::ACQ_CYCLES,
  parameter int unsigned CONV_CYC  = adc_host_pkg::CONV_CYCLES,
  parameter int unsigned SCLK_HALF = adc_host_pkg::SCLK_HALF_CYCLES,
  parameter int unsigned BUF_DEPTH = adc_host_pkg::BUF_DEPTH
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reset_pin,
  input  wire logic        i_power_down_in,
  input  wire logic        i_convert_start_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_serial_mode_select,
  input  wire logic        i_external_clock_select,
  input  wire logic        i_serial_clock_invert,
  input  wire logic        i_frame_sync_invert,
  input  wire logic        i_read_during_conv_select,
  input  wire logic        i_sclk_in,
  input  wire logic [15:0] i_sample_value,
  output logic             o_busy,
  output logic             o_hold,
  output logic             o_power_reduced,
  output logic [15:0]      o_data,
  output logic [15:0]      o_data_oe
);

  generate
    if (ACQ_CYC < 1 || ACQ_CYC > 65535 || CONV_CYC < 1 || CONV_CYC > 65535
        || SCLK_HALF < 1 || SCLK_HALF > 255)
    begin : g_bad_par
      $error("counts out of range for the 16-bit and 8-bit counters");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops per bit

  logic [10:0]              async_in;
  logic [10:0]              meta_q;
  logic [10:0]              sync_q;
  adc_host_pkg::mode_cfg_t  cfg;
  adc_host_pkg::host_pins_t pins;

  assign async_in = {i_serial_mode_select, i_external_clock_select, i_serial_clock_invert,
                     i_frame_sync_invert, i_read_during_conv_select, i_cs_n, i_rd_n,
                     i_convert_start_n, i_power_down_in, i_reset_pin, i_sclk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++)
    begin : g_sync
      // first stage feeds only the second
      always_ff @(posedge i_sys_clk)
      begin
        if (!i_rst_n)
        begin
          meta_q[gi] <= adc_host_pkg::SYNC_RESET[gi];
          sync_q[gi] <= adc_host_pkg::SYNC_RESET[gi];
        end
        else
        begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign cfg  = sync_q[10:6];
  assign pins = sync_q[5:0];

  // the reset pin acts as a second synchronous reset
  logic rst_ok;
  assign rst_ok = i_rst_n && !pins.reset;

  ////////////////////////////////////////////////////////////////////////////////
  // edge history for the start pin and the external serial clock

  logic convert_start_n_prev_q;
  logic sclk_prev_q;
  logic convert_start_n_fall;
  logic sclk_rise;
  logic sclk_fall;

  always_comb
  begin
    convert_start_n_fall = convert_start_n_prev_q && !pins.convert_start_n_n;
    sclk_rise  = !sclk_prev_q && pins.sclk;
    sclk_fall  = sclk_prev_q && !pins.sclk;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!rst_ok)
    begin
      convert_start_n_prev_q <= 1'b1;
      sclk_prev_q  <= 1'b0;
    end
    else
    begin
      convert_start_n_prev_q <= pins.convert_start_n_n;
      sclk_prev_q  <= pins.sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  adc_host_pkg::conv_state_t st_q;
  adc_host_pkg::conv_state_t st_d;
  logic [15:0]               cnt_q;
  logic [15:0]               cnt_d;
  logic                      buf_in_valid;
  logic                      buf_in_ready;
  logic                      conv_done;

  always_comb
  begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    buf_in_valid = 1'b0;
    unique case (st_q)
      adc_host_pkg::CV_ACQ:
      begin
        if (cnt_q >= 16'(ACQ_CYC - 1))
        begin
          cnt_d = '0;
          if (pins.pd)
            st_d = adc_host_pkg::CV_PDN;
          else if (!pins.convert_start_n_n)
            st_d = adc_host_pkg::CV_CONV;
          else
            st_d = adc_host_pkg::CV_WAIT;
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      adc_host_pkg::CV_WAIT:
      begin
        if (pins.pd)
          st_d = adc_host_pkg::CV_PDN;
        else if (convert_start_n_fall)
          st_d = adc_host_pkg::CV_CONV;
      end
      adc_host_pkg::CV_CONV:
      begin
        // power down is not looked at here so the conversion always ends
        if (cnt_q >= 16'(CONV_CYC - 1))
        begin
          buf_in_valid = 1'b1;
          if (buf_in_ready)
          begin
            st_d  = adc_host_pkg::CV_ACQ;
            cnt_d = '0;
          end
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      adc_host_pkg::CV_PDN:
      begin
        if (!pins.pd)
          st_d = adc_host_pkg::CV_ACQ;
      end
    endcase
    conv_done = buf_in_valid && buf_in_ready;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!rst_ok)
    begin
      st_q  <= adc_host_pkg::CV_ACQ;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // busy ends in the cycle after the result is taken by the buffer
  assign o_busy          = (st_q == adc_host_pkg::CV_CONV);
  assign o_hold          = (st_q == adc_host_pkg::CV_CONV);
  assign o_power_reduced = (st_q == adc_host_pkg::CV_PDN);

  ////////////////////////////////////////////////////////////////////////////////
  // result buffer: holds a fresh result while a serial read is in flight

  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [15:0] buf_out_data;

  adc_result_buffer #(
    .WIDTH (adc_host_pkg::WORD_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (rst_ok),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (i_sample_value),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_out_ready),
    .o_out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // output word, serial shifter and pin drive

  logic [15:0] word_q;
  logic [15:0] word_d;
  logic        have_q;
  logic        have_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0]  bits_q;
  logic [4:0]  bits_d;
  logic        act_q;
  logic        act_d;
  logic        done_q;
  logic        done_d;
  logic        isclk_q;
  logic        isclk_d;
  logic [7:0]  div_q;
  logic [7:0]  div_d;
  logic        ovr_q;
  logic        ovr_d;
  logic [15:0] pin_q;
  logic [15:0] pin_d;
  logic [15:0] oe_q;
  logic [15:0] oe_d;
  logic        bus_en;
  logic        ext_upd;
  logic        frame;

  always_comb
  begin
    word_d  = word_q;
    have_d  = have_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    act_d   = act_q;
    done_d  = done_q;
    isclk_d = isclk_q;
    div_d   = div_q;
    ovr_d   = 1'b0;
    bus_en  = !pins.cs_n && !pins.rd_n;
    // external edges count only while selected
    ext_upd = !pins.cs_n && (cfg.inv_sclk ? sclk_fall : sclk_rise);
    // a result moves to the output word at once unless a read owns it
    buf_out_ready = !act_q;
    if (buf_out_ready && buf_out_valid)
    begin
      word_d = buf_out_data;
      have_d = 1'b1;
      done_d = 1'b0;
    end
    if (!bus_en)
      done_d = 1'b0;
    if (cfg.serial && !act_q && !done_q && have_q && bus_en)
    begin
      // internal clock may read the held word during a conversion only with rd_conv set
      if (cfg.ext_clk || cfg.rd_conv || st_q != adc_host_pkg::CV_CONV)
      begin
        // a word popped in this same cycle is the one to send, not the stale one
        shift_d = word_d;
        bits_d  = 5'(adc_host_pkg::WORD_BITS);
        act_d   = 1'b1;
        isclk_d = 1'b0;
        div_d   = '0;
      end
    end
    else if (act_q && cfg.ext_clk)
    begin
      if (conv_done)
      begin
        // the half-read word is dropped for the new result
        act_d  = 1'b0;
        done_d = 1'b0;
        ovr_d  = 1'b1;
      end
      else if (ext_upd)
      begin
        shift_d = {shift_q[14:0], 1'b0};
        bits_d  = bits_q - 5'h01;
        if (bits_q == 5'h01)
        begin
          act_d  = 1'b0;
          done_d = 1'b1;
        end
      end
    end
    else if (act_q)
    begin
      // generated clock: data moves on its falling edge
      if (div_q >= 8'(SCLK_HALF - 1))
      begin
        div_d   = '0;
        isclk_d = !isclk_q;
        if (isclk_q)
        begin
          shift_d = {shift_q[14:0], 1'b0};
          bits_d  = bits_q - 5'h01;
          if (bits_q == 5'h01)
          begin
            act_d  = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      else
        div_d = div_q + 8'h01;
    end
    frame = (act_q && !cfg.ext_clk) ^ cfg.inv_sync;
    // pin levels and enables, registered so the pins never glitch
    pin_d = word_q;
    oe_d  = {16{bus_en}};
    if (cfg.serial)
    begin
      pin_d[adc_host_pkg::SERIAL_IN_TOP:0] = '0;
      oe_d[adc_host_pkg::SERIAL_IN_TOP:0]  = '0;
      pin_d[adc_host_pkg::SERIAL_DATA_OUT_POS]       = shift_q[15];
      pin_d[adc_host_pkg::SCLK_POS]        = isclk_q;
      oe_d[adc_host_pkg::SCLK_POS]         = bus_en && !cfg.ext_clk;
      pin_d[adc_host_pkg::SYNC_POS]        = frame;
      pin_d[adc_host_pkg::OVR_POS]         = ovr_q;
    end
    // the top nibble never turns around outside reset
    oe_d[15:adc_host_pkg::UPPER_LSB] = '1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!rst_ok)
    begin
      word_q  <= adc_host_pkg::RESULT_RESET;
      have_q  <= 1'b0;
      shift_q <= adc_host_pkg::RESULT_RESET;
      bits_q  <= '0;
      act_q   <= 1'b0;
      done_q  <= 1'b0;
      isclk_q <= 1'b0;
      div_q   <= '0;
      ovr_q   <= 1'b0;
      pin_q   <= '0;
      oe_q    <= '0;
    end
    else
    begin
      word_q  <= word_d;
      have_q  <= have_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
      act_q   <= act_d;
      done_q  <= done_d;
      isclk_q <= isclk_d;
      div_q   <= div_d;
      ovr_q   <= ovr_d;
      pin_q   <= pin_d;
      oe_q    <= oe_d;
    end
  end

  assign o_data    = pin_q;
  assign o_data_oe = oe_q;

endmodule

// File: sim/adc_host_if_chk.sv
module adc_host_if_chk #(
  parameter int unsigned CONV_CYC = 8
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reset_pin,
  input  wire logic        i_power_down_in,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_serial_mode_select,
  input  wire logic        i_external_clock_select,
  input  wire logic        o_busy,
  input  wire logic [15:0] o_data,
  input  wire logic [15:0] o_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] blen_q;
  logic [7:0] blen_d;

  // busy length; saturates so a long buffer stall cannot wrap it
  always_comb
  begin
    blen_d = o_busy ? blen_q + {7'h00, blen_q != 8'hFF} : 8'h00;
  end

  always_ff @(posedge i_sys_clk)
  begin
    blen_q <= i_rst_n ? blen_d : 8'h00;
  end

  //////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_upper_oe: assert property (
    (i_rst_n && !i_reset_pin)[*5] |-> o_data_oe[15:12] == 4'hF) else $error("top nibble undriven");
  chk_oe_gate: assert property (
    (i_cs_n || i_rd_n)[*5] |-> o_data_oe[11:0] == 12'h000) else $error("bus driven unselected");
  chk_par_full: assert property (
    (!i_serial_mode_select && !i_cs_n && !i_rd_n)[*5] |-> o_data_oe == 16'hFFFF)
    else $error("parallel bus not driven");
  chk_serial_low: assert property (
    i_serial_mode_select[*5] |-> o_data_oe[7:0] == 8'h00) else $error("low byte driven");
  chk_busy_len: assert property (
    $fell(o_busy) && !i_reset_pin |-> blen_q >= 8'(CONV_CYC)) else $error("busy too short");
  chk_reset_abort: assert property (
    i_reset_pin[*5] |-> !o_busy) else $error("busy during reset pin");
  chk_pd_inhibit: assert property (
    (i_power_down_in && !o_busy)[*4] |=> !o_busy) else $error("conversion in power down");
  chk_ovr_pulse: assert property (
    $rose(o_data[11]) && i_serial_mode_select && i_external_clock_select
    && $past(i_serial_mode_select, 3) |=> !o_data[11]) else $error("overrun not one cycle");
endmodule

bind adc_host_if adc_host_if_chk #(.CONV_CYC(CONV_CYC)) i_adc_host_if_chk (.i_sys_clk, .i_rst_n,
  .i_reset_pin, .i_power_down_in, .i_cs_n, .i_rd_n, .i_serial_mode_select,
  .i_external_clock_select, .o_busy, .o_data, .o_data_oe);

// File: sim/adc_host_model.sv
module adc_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_inv,
  input  wire logic i_sdata,
  input  wire logic i_gclk,
  output logic      o_cs_n,
  output logic      o_rd_n,
  output logic      o_sclk
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_sclk = 1'b0;
  end

  // clock parks at its idle level before select, so no stray edge is seen
  task automatic select(input logic on);
    o_sclk = i_inv;
    repeat (4) @(negedge i_sys_clk);
    o_cs_n = !on;
    o_rd_n = !on;
  endtask

  // external clock: sample, then make the update edge, 200 ns each phase
  task automatic shift(input int n, output logic [15:0] word);
    word = 16'h0000;
    repeat (4) @(negedge i_sys_clk);
    repeat (n)
    begin
      repeat (4) @(negedge i_sys_clk);
      word = {word[14:0], i_sdata};
      o_sclk = !i_inv;
      repeat (4) @(negedge i_sys_clk);
      o_sclk = i_inv;
    end
  endtask

  // internal clock: take a bit on each rise of the generated clock
  task automatic capture(output logic [15:0] word);
    int   n;
    logic prev;
    word = 16'h0000;
    n = 0;
    prev = i_gclk;
    for (int t = 0; t < 200 && n < 16; t++)
    begin
      @(negedge i_sys_clk);
      if (i_gclk && !prev)
      begin
        word = {word[14:0], i_sdata};
        n++;
      end
      prev = i_gclk;
    end
  endtask
endmodule

// File: sim/tb_adc_host_if.sv
module tb_adc_host_if;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned ACQ = 4;

  logic        clk;
  logic        rst_n;
  logic        reset_pin;
  logic        pd;
  logic        cnv_n;
  logic        cs_n;
  logic        rd_n;
  logic        ser;
  logic        ext;
  logic        inv_sclk;
  logic        inv_sync;
  logic        rdc;
  logic        sclk;
  logic [15:0] sample;
  logic        busy;
  logic        hold;
  logic        pwr_low;
  logic [15:0] data;
  logic [15:0] oe;
  int          error_cnt;
  int          check_count;

  adc_host_if #(.ACQ_CYC(ACQ), .CONV_CYC(8), .SCLK_HALF(2), .BUF_DEPTH(2)) i_adc_host_if (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reset_pin(reset_pin), .i_power_down_in(pd),
    .i_convert_start_n(cnv_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_serial_mode_select(ser),
    .i_external_clock_select(ext), .i_serial_clock_invert(inv_sclk),
    .i_frame_sync_invert(inv_sync), .i_read_during_conv_select(rdc), .i_sclk_in(sclk),
    .i_sample_value(sample), .o_busy(busy), .o_hold(hold), .o_power_reduced(pwr_low),
    .o_data(data), .o_data_oe(oe));

  adc_host_model i_adc_host_model (.i_sys_clk(clk), .i_inv(inv_sclk), .i_sdata(data[8]),
    .i_gclk(data[9]), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_sclk(sclk));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  //////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait; a hang ends the run at once
  task automatic wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 400 && busy !== lvl; n++) @(negedge clk);
    if (n == 400)
    begin
      check("busy wait", {15'h0, lvl}, {15'h0, busy});
      conclude();
    end
  endtask

  task automatic convert(input logic [15:0] v);
    sample = v;
    cnv_n = 1'b0;
    wait_busy(1'b1);
    check("hold", 16'h0001, {15'h0, hold});
    @(negedge clk);
    cnv_n = 1'b1;
    wait_busy(1'b0);
  endtask

  //////////////////////////////
  task automatic test_parallel();
    int n;
    convert(16'hA5C3);
    i_adc_host_model.select(1'b1);
    repeat (6) @(negedge clk);
    check("par data", 16'hA5C3, data);
    check("par oe", 16'hFFFF, oe);
    i_adc_host_model.select(1'b0);
    repeat (6) @(negedge clk);
    check("idle oe", 16'hF000, oe);
    // start held low: the next conversion needs no edge
    cnv_n = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge clk);
    check("restart", 16'h0001, 16'(n <= ACQ + 4));
    cnv_n = 1'b1;
    wait_busy(1'b0);
    $display("test_parallel done");
  endtask

  task automatic test_serial_ext();
    logic [15:0] w;
    ser = 1'b1;
    ext = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      inv_sclk = k[0];
      convert(16'h9E61 + 16'(k));
      i_adc_host_model.select(1'b1);
      i_adc_host_model.shift(16, w);
      check("ext word", 16'h9E61 + 16'(k), w);
      i_adc_host_model.select(1'b0);
    end
    $display("test_serial_ext done");
  endtask

  // a conversion ends while a read is half done
  task automatic test_overrun();
    logic [15:0] w;
    logic        seen;
    i_adc_host_model.select(1'b1);
    i_adc_host_model.shift(2, w);
    check("ext head", 16'h0002, w);
    convert(16'h0F0F);
    seen = 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      seen |= data[11];
    end
    check("overrun", 16'h0001, {15'h0, seen});
    // the fresh result is offered at once and must read out whole
    i_adc_host_model.shift(16, w);
    check("ext new", 16'h0F0F, w);
    i_adc_host_model.select(1'b0);
    $display("test_overrun done");
  endtask

  task automatic test_serial_int();
    logic [15:0] w;
    ext = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      inv_sync = k[0];
      rdc = k[0];
      convert(16'hC35A ^ 16'(k));
      i_adc_host_model.select(1'b1);
      i_adc_host_model.capture(w);
      check("int sync", {15'h0, !k[0]}, {15'h0, data[10]});
      check("int word", 16'hC35A ^ 16'(k), w);
      i_adc_host_model.select(1'b0);
    end
    $display("test_serial_int done");
  endtask

  task automatic test_power_reset();
    logic seen;
    pd = 1'b1;
    repeat (20) @(negedge clk);
    cnv_n = 1'b0;
    seen = 1'b0;
    repeat (30)
    begin
      @(negedge clk);
      seen |= busy;
    end
    check("pd busy", 16'h0000, {15'h0, seen});
    check("pd state", 16'h0001, {15'h0, pwr_low});
    pd = 1'b0;
    wait_busy(1'b1);
    reset_pin = 1'b1;
    repeat (6) @(negedge clk);
    check("abort", 16'h0000, {15'h0, busy});
    cnv_n = 1'b1;
    reset_pin = 1'b0;
    repeat (6) @(negedge clk);
    $display("test_power_reset done");
  endtask

  //////////////////////////////
  initial
  begin
    {rst_n, reset_pin, pd, ser, ext, inv_sclk, inv_sync, rdc} = 8'h00;
    cnv_n = 1'b1;
    sample = 16'h0000;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    test_parallel();
    test_serial_ext();
    test_overrun();
    test_serial_int();
    test_power_reset();
    conclude();
  end
endmodule
